// File: design/scrs_clkdiv.sv
// Notes on behaviour
// - source-select strap at 1 feeds the generator from the external input
// - without a running rtc clock, addresses 1900h to 197fh are not accessible
// - boot spi clock is input divided by 25, i2c and uart by 32
// - boot clocks follow the real input edges, so faster input runs faster
`timescale 1ns/1ns
package scrs_pkg;
  localparam int MCLK_HZ = 100_000_000;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int CNT_W = 32;
  localparam int PLL_SETTLE_MS = 4;
  localparam int PLL_SETTLE_CYC = PLL_SETTLE_MS * (MCLK_HZ / 1000);
  localparam int RTC_CLK_HZ = 32768;
  localparam int RTC_TIMEOUT_CYC = 2 * (MCLK_HZ / RTC_CLK_HZ);
  localparam int EXT_REF_MAX_MHZ = 24;
  localparam int SPI_BOOT_DIV = 25;
  localparam int SER_BOOT_DIV = 32;
  localparam logic [15:0] RTC_ADDR_FIRST = 16'h1900;
  localparam logic [15:0] RTC_ADDR_LAST = 16'h197f;
  localparam logic EXT_SEL_VALUE = 1'h1;
  localparam logic [1:0] SEL_CAPTURE_CYC = 2'h2;
  localparam int PIN_N = 3;
  localparam int PIN_EXT = 0;
  localparam int PIN_RTC = 1;
  localparam int PIN_SEL = 2;
  typedef enum logic [1:0] {PLL_IDLE, PLL_WAIT, PLL_READY} scrs_pll_t;
endpackage

module scrs_clkdiv import scrs_pkg::*; #(
  parameter int DIV = SPI_BOOT_DIV
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic tick,
  output logic divOut
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  localparam logic [W-1:0] HALF = W'(DIV / 2);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic divOut_r;

  always_comb begin
    cnt_nxt = (cnt_r == LAST) ? '0 : W'(cnt_r + 1'b1);
  end

  // only real edges advance
  // idle at the wrap point so the first edge opens a full high phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= LAST;
      divOut_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= LAST;
      divOut_r <= 1'b0;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
      divOut_r <= (cnt_nxt < HALF);
    end
  end

  assign divOut = divOut_r;

  sequence wrapSeq;
    run && tick && cnt_r == LAST;
  endsequence

  property wrapToZero;
    @(posedge mclk) disable iff (!rst_b) wrapSeq |=> cnt_r == '0;
  endproperty

  div_wrap_a: assert property (wrapToZero)
    else $error("divider did not wrap at its ratio");

  div_rise_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $rose(divOut_r) |-> cnt_r == '0 && $past(cnt_r) == LAST)
    else $error("divided clock rose off the wrap point");

  div_hold_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    run && !tick |=> $stable(cnt_r))
    else $error("divider moved without an input edge");
endmodule

// File: design/scrs_top.sv
`timescale 1ns/1ns
module scrs_top import scrs_pkg::*; #(
  parameter int PLL_SETTLE_CYCLES = PLL_SETTLE_CYC,
  parameter int RTC_TIMEOUT_CYCLES = RTC_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic extRefClkPin,
  input wire logic rtcCrystalInPin,
  input wire logic clkSelPin,
  input wire logic bootActive,
  input wire logic pllProgram,
  input wire logic ioReq,
  input wire logic [15:0] ioAddr,
  output logic sysRefSample,
  output logic clkSelLatched,
  output logic spiBootClk,
  output logic serBootClk,
  output logic rtcAlive,
  output logic ioGrant,
  output logic ioRtcBlocked,
  output logic pllSettled
);
  logic [1:0] rstPipe_r;
  logic rstSync_b;
  logic [PIN_N-1:0] pinMeta_r;
  logic [PIN_N-1:0] pinSync_r;
  logic extPrev_r;
  logic rtcPrev_r;
  logic extEdge;
  logic rtcEdge;
  logic [1:0] capCnt_r;
  logic capDone_r;
  logic clkSel_r;
  logic sysRef_r;
  logic [CNT_W-1:0] rtcCnt_r;
  logic rtcAlive_r;
  logic ioGrant_r;
  logic ioBlocked_r;
  scrs_pll_t pllState_r;
  logic [CNT_W-1:0] pllCnt_r;
  logic pllSettled_r;

  function automatic logic isRtcAddr(input logic [15:0] a);
    isRtcAddr = (a >= RTC_ADDR_FIRST) && (a <= RTC_ADDR_LAST);
  endfunction

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe_r[1];

  // pins are asynchronous; first stage feeds only the second
  generate
    for (genvar i = 0; i < PIN_N; i++) begin : g_sync
      always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
          pinMeta_r[i] <= 1'b0;
          pinSync_r[i] <= 1'b0;
        end else begin
          pinMeta_r[i] <= (i == PIN_EXT) ? extRefClkPin :
                          (i == PIN_RTC) ? rtcCrystalInPin : clkSelPin;
          pinSync_r[i] <= pinMeta_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      extPrev_r <= 1'b0;
      rtcPrev_r <= 1'b0;
    end else begin
      extPrev_r <= pinSync_r[PIN_EXT];
      rtcPrev_r <= pinSync_r[PIN_RTC];
    end
  end
  assign extEdge = pinSync_r[PIN_EXT] && !extPrev_r;
  assign rtcEdge = pinSync_r[PIN_RTC] && !rtcPrev_r;

  // strap is static, so capture once after release
  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      capCnt_r <= 2'h0;
      capDone_r <= 1'b0;
      clkSel_r <= 1'b0;
    end else if (!capDone_r) begin
      if (capCnt_r == SEL_CAPTURE_CYC) begin
        capDone_r <= 1'b1;
        clkSel_r <= pinSync_r[PIN_SEL];
      end else begin
        capCnt_r <= capCnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      sysRef_r <= 1'b0;
    end else begin
      sysRef_r <= (clkSel_r == EXT_SEL_VALUE) ? pinSync_r[PIN_EXT]
                                              : pinSync_r[PIN_RTC];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rtcCnt_r <= '0;
      rtcAlive_r <= 1'b0;
    end else if (rtcEdge) begin
      rtcCnt_r <= '0;
      rtcAlive_r <= 1'b1;
    end else if (rtcCnt_r == CNT_W'(RTC_TIMEOUT_CYCLES - 1)) begin
      rtcAlive_r <= 1'b0;
    end else begin
      rtcCnt_r <= rtcCnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ioGrant_r <= 1'b0;
      ioBlocked_r <= 1'b0;
    end else begin
      ioGrant_r <= ioReq && !(isRtcAddr(ioAddr) && !rtcAlive_r);
      ioBlocked_r <= ioReq && isRtcAddr(ioAddr) && !rtcAlive_r;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pllState_r <= PLL_IDLE;
      pllCnt_r <= '0;
      pllSettled_r <= 1'b0;
    end else if (pllProgram) begin
      pllState_r <= PLL_WAIT;
      pllCnt_r <= '0;
      pllSettled_r <= 1'b0;
    end else begin
      case (pllState_r)
        PLL_IDLE: begin
          pllSettled_r <= 1'b0;
        end
        PLL_WAIT: begin
          if (pllCnt_r == CNT_W'(PLL_SETTLE_CYCLES - 1)) begin
            pllState_r <= PLL_READY;
            pllSettled_r <= 1'b1;
          end else begin
            pllCnt_r <= pllCnt_r + 1'b1;
          end
        end
        PLL_READY: begin
          pllSettled_r <= 1'b1;
        end
        default: begin
          pllState_r <= PLL_IDLE;
          pllSettled_r <= 1'b0;
        end
      endcase
    end
  end

  scrs_clkdiv #(.DIV(SPI_BOOT_DIV)) u_spiDiv (
    .mclk(mclk),
    .rst_b(rstSync_b),
    .run(bootActive),
    .tick(extEdge),
    .divOut(spiBootClk)
  );

  scrs_clkdiv #(.DIV(SER_BOOT_DIV)) u_serDiv (
    .mclk(mclk),
    .rst_b(rstSync_b),
    .run(bootActive),
    .tick(extEdge),
    .divOut(serBootClk)
  );

  assign sysRefSample = sysRef_r;
  assign clkSelLatched = clkSel_r;
  assign rtcAlive = rtcAlive_r;
  assign ioGrant = ioGrant_r;
  assign ioRtcBlocked = ioBlocked_r;
  assign pllSettled = pllSettled_r;

  ref_select_a: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    capDone_r |=> sysRef_r == (clkSel_r ? $past(pinSync_r[PIN_EXT])
                                        : $past(pinSync_r[PIN_RTC])))
    else $error("reference sample not from selected source");

  rtc_block_a: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    ioReq && isRtcAddr(ioAddr) && !rtcAlive_r |=> ioBlocked_r && !ioGrant_r)
    else $error("rtc range reached without rtc clock");

  other_pass_a: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    ioReq && !isRtcAddr(ioAddr) |=> ioGrant_r && !ioBlocked_r)
    else $error("non-rtc access refused");

  rtc_alive_a: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    rtcEdge |=> rtcAlive_r && rtcCnt_r == '0)
    else $error("rtc edge did not mark clock alive");

  settle_wait_a: assert property (
    @(posedge mclk) disable iff (!rstSync_b)
    pllProgram |=> !pllSettled_r [*2])
    else $error("settled flag rose too soon after programming");
endmodule

// File: dv/scrs_src_model.sv
`timescale 1ns/1ns
module scrs_src_model #(
  parameter int EXT_HALF_NS = 40,
  parameter int RTC_HALF_NS = 30
) (
  input wire logic extRun,
  input wire logic rtcRun,
  output logic extClk,
  output logic rtcClk
);
  // 80 ns period, well under 24 MHz
  initial extClk = 1'h0;
  always #(EXT_HALF_NS) extClk = extRun ? ~extClk : 1'h0;
  // rtc sped up so the liveness watchdog fits a short run
  // a stopped oscillator parks low, never holds a stale level
  initial rtcClk = 1'h0;
  always #(RTC_HALF_NS) rtcClk = rtcRun ? ~rtcClk : 1'h0;
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
  mismatches++; $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module tb_top;
  logic mclk = 1'h0, rst_b = 1'h0, clkSelPin = 1'h1, bootActive = 1'h0;
  logic pllProgram = 1'h0, ioReq = 1'h0, extRun = 1'h0, rtcRun = 1'h0;
  logic [15:0] ioAddr = 16'h0000;
  logic extClk, rtcClk, sysRef, selL, spiClk, serClk, alive, grant, blk;
  logic settled, seen;
  int mismatches = 0, num_checks = 0, extCnt = 0, a, n;
  time t;
  localparam int SETTLE = 20;
  // rtc on, grant, blocked, address
  logic [18:0] rows [6] = '{19'h11900, 19'h218ff, 19'h1197f, 19'h21980,
    19'h61900, 19'h6197f};
  always #5 mclk = ~mclk;
  always @(posedge extClk) extCnt++;
  scrs_src_model i_src (.extRun(extRun), .rtcRun(rtcRun), .extClk(extClk),
    .rtcClk(rtcClk));
  scrs_top #(.PLL_SETTLE_CYCLES(SETTLE), .RTC_TIMEOUT_CYCLES(16)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .extRefClkPin(extClk),
    .rtcCrystalInPin(rtcClk), .clkSelPin(clkSelPin),
    .bootActive(bootActive), .pllProgram(pllProgram), .ioReq(ioReq),
    .ioAddr(ioAddr), .sysRefSample(sysRef), .clkSelLatched(selL),
    .spiBootClk(spiClk), .serBootClk(serClk), .rtcAlive(alive),
    .ioGrant(grant), .ioRtcBlocked(blk), .pllSettled(settled));
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic do_reset(input logic sel);
    @(posedge mclk) rst_b <= 1'h0;
    clkSelPin <= sel;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("latched in reset", 1'h0, selL)
    @(posedge mclk) rst_b <= 1'h1;
    repeat (10) @(posedge mclk);
    #1;
    `CHK("latched", sel, selL)
    $display("test reset done");
  endtask
  task automatic ref_seen(input logic e);
    seen = 1'h0;
    repeat (16) begin
      @(posedge mclk);
      #1;
      seen = seen | sysRef;
    end
    `CHK("ref toggles", e, seen)
  endtask
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    do_reset(1'h1);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk) rtcRun <= rows[i][18];
      repeat (30) @(posedge mclk);
      #1;
      `CHK("alive", rows[i][18], alive)
      @(posedge mclk) ioAddr <= rows[i][15:0];
      ioReq <= 1'h1;
      @(posedge mclk) ioReq <= 1'h0;
      #1;
      `CHK("grant", rows[i][17], grant)
      `CHK("blocked", rows[i][16], blk)
    end
    $display("test io done");
    ref_seen(1'h0);
    @(posedge mclk) extRun <= 1'h1;
    bootActive <= 1'h1;
    ref_seen(1'h1);
    @(posedge spiClk) a = extCnt;
    t = $time;
    @(posedge spiClk);
    `CHK("spi div", 25, extCnt - a)
    `CHK("spi ns", 2000, $time - t)
    @(posedge serClk) a = extCnt;
    @(posedge serClk);
    `CHK("ser div", 32, extCnt - a)
    $display("test boot dividers done");
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) pllProgram <= 1'h1;
      @(posedge mclk) pllProgram <= 1'h0;
      n = 0;
      #1;
      `CHK("settle cleared", 1'h0, settled)
      while (settled !== 1'h1 && n < 100) begin
        @(posedge mclk);
        #1;
        n++;
      end
      `CHK("settle cycles", SETTLE, n)
    end
    $display("test pll done");
    do_reset(1'h0);
    // rtc selected and running, ext running too
    ref_seen(1'h1);
    @(posedge mclk) rtcRun <= 1'h0;
    // let the stopped oscillator park and pass the sync stages
    repeat (8) @(posedge mclk);
    ref_seen(1'h0);
    $display("test rtc source done");
    close_out();
  end
endmodule
